// ===== core/tmie_consts.vh
// constants of the instruction execute core: opcode fields, flag positions,
// flag masks, register offsets, reset values and cycle counts.
// assumes inclusion by the core and by its testbench.
`ifndef TMIE_CONSTS_VH
`define TMIE_CONSTS_VH

// major opcode, instruction bits [15:12]
`define TMIE_OP_MISC 4'h0
`define TMIE_OP_ADD_CARRY 4'h1
`define TMIE_OP_CMP_SKIP 4'h2
`define TMIE_OP_SUBC_K 4'h3
`define TMIE_OP_AND_K 4'h4
`define TMIE_OP_CLR_MASK 4'h5
`define TMIE_OP_ADD_WORD 4'h6
`define TMIE_OP_SUB_WORD 4'h7
`define TMIE_OP_IO_BIT 4'h8
`define TMIE_OP_BRANCH 4'h9
`define TMIE_OP_TFLAG 4'ha
`define TMIE_OP_MEM 4'hb
`define TMIE_OP_LOAD_DISP 4'hc
// misc group, bits [11:8]
`define TMIE_MISC_NOP 4'h0
`define TMIE_MISC_CALL_Z 4'h1
`define TMIE_MISC_FLAG_SET 4'h2
`define TMIE_MISC_FLAG_CLR 4'h3
`define TMIE_MISC_ROTATE 4'h4
`define TMIE_MISC_PUSH 4'h5
`define TMIE_MISC_STORE_DIRECT 4'h6
// io bit group, bits [11:10]
`define TMIE_IO_SET 2'h0
`define TMIE_IO_CLEAR 2'h1
`define TMIE_IO_SKIP_SET 2'h2
`define TMIE_IO_SKIP_CLEAR 2'h3
// branch group, bits [11:10]
`define TMIE_BR_FLAG_SET 2'h0
`define TMIE_BR_FLAG_CLEAR 2'h1
`define TMIE_BR_GE_SIGNED 2'h2
`define TMIE_BR_LT_SIGNED 2'h3
// pointer memory group, bits [11:10]
`define TMIE_MEM_LOAD_PREDEC 2'h0
`define TMIE_MEM_WRITE_POSTINC 2'h1
`define TMIE_MEM_PM_POSTINC 2'h2
// status register bit positions
`define TMIE_SR_C 0
`define TMIE_SR_Z 1
`define TMIE_SR_N 2
`define TMIE_SR_V 3
`define TMIE_SR_S 4
`define TMIE_SR_H 5
`define TMIE_SR_T 6
// flag update masks
`define TMIE_FM_ARITH 8'h2f
`define TMIE_FM_LOGIC 8'h0e
`define TMIE_FM_WORD 8'h1f
`define TMIE_FM_SHIFT 8'h0f
`define TMIE_MASK_ALL 8'hff
// apb register byte offsets
`define TMIE_ADDR_CTRL 12'h000
`define TMIE_ADDR_PC 12'h004
`define TMIE_ADDR_STATUS 12'h008
`define TMIE_ADDR_SP 12'h00c
`define TMIE_CTRL_RUN 0
`define TMIE_RUN_RESET 1'b1
`define TMIE_SP_RESET 16'h00ff
// extra wait cycles after the issue cycle
`define TMIE_WAIT_2CLK 2'h1
`define TMIE_WAIT_3CLK 2'h2

`endif

// ===== core/tmie_core.v
// instruction decode and execute core of a small 8-bit controller,
// with an apb slave for run control and state readback.
// assumes program and data memory answer combinationally to the address
// outputs, and that all inputs are synchronous to pclk.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "tmie_consts.vh"

// Overview of operation
// RL1 - add with carry: d = d + r + C, updates Z C N V H, one clock
// RL2 - word add immediate on a pair, updates Z C N V S, two clocks
// RL3 - word subtract immediate on a pair, updates Z C N V S, two clocks
// RL4 - subtract constant with carry, updates Z C N V H, one clock
// RL5 - clear bits: d AND (0xff minus mask), updates only Z N V
// RL6 - AND with constant, updates only Z N V, one clock
// RL7 - indirect call pushes return, jumps to Z pair, three clocks, no flags
// RL8 - compare and skip if equal: 1, 2 or 3 clocks
// RL9 - skip if io bit set: 1, 2 or 3 clocks like other skips
// RL10 - branch on status bit set: pc + k + 1, two clocks taken, one not
// RL11 - signed ge branch when N xor V is 0, lt when it is 1
// RL12 - set or clear one io bit in two clocks, no flag change
// RL13 - rotate right through carry, updates Z C N V, one clock
// RL14 - bit store copies register bit into T, one clock, only T changes
// RL15 - bit load copies T into register bit, one clock, no flags
// RL16 - pre-decrement load: decrement pointer, then read, two clocks
// RL17 - post-increment write: write at pointer, then increment, two clocks
// RL18 - displaced load reads pointer plus offset, pointer unchanged, two clocks
// RL19 - program memory read at Z into d, increment Z, three clocks
// RL20 - push writes register to stack, moves stack pointer, two clocks
// RL21 - overflow flag set and clear, one clock each
// RL22 - io bit set, clear and skip reach io addresses 0x00 to 0x1f only
// RL23 - io bit set and clear write only the addressed bit
// RL24 - multi-cycle operations hold fetch and issue for their full count
module tmie_core (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // program memory
  output wire [15:0] pm_addr,
  input wire [15:0] pm_rdata,
  // data memory
  output reg [15:0] dm_addr,
  output reg [7:0] dm_wdata,
  output reg dm_we,
  output reg dm_re,
  input wire [7:0] dm_rdata,
  // bit-addressable io
  output reg [4:0] io_bit_addr,
  output reg [2:0] io_bit_num,
  output reg io_bit_val,
  output reg io_bit_we,
  input wire [255:0] io_low_view
);

  // phases of the extra cycles
  localparam PH_IDLE = 3'h0;
  localparam PH_LOAD = 3'h1;
  localparam PH_PMREAD = 3'h2;
  localparam PH_CALL_HI = 3'h3;
  localparam PH_STORE_DIRECT = 3'h4;

  reg [7:0] rf [0:31];
  reg [15:0] pc;
  reg [15:0] sp;
  reg [7:0] status_register;
  reg [1:0] wait_cnt;
  reg [2:0] phase;
  reg [4:0] hold_d;
  reg hold_b;
  reg [15:0] ret_pc;
  reg skip_next;
  reg skip_raw;
  reg run_en;
  integer i;

  // merge new flag values under a mask
  function [7:0] fmerge;
    input [7:0] old;
    input [7:0] nw;
    input [7:0] m;
    begin
      fmerge = (old & ~m) | (nw & m);
    end
  endfunction

  // flag byte from half carry, sign, overflow, carry and 8-bit result
  function [7:0] fbyte;
    input h;
    input s;
    input v;
    input c;
    input [7:0] r;
    begin
      fbyte = {2'b00, h, s, v, r[7], (r == 8'h00), c};
    end
  endfunction

  // 8-bit add or subtract with carry in; returns {h, v, c, result}
  function [10:0] alu8;
    input [7:0] a;
    input [7:0] b;
    input ci;
    input sub;
    reg [8:0] s;
    reg [4:0] hs;
    reg v;
    begin
      if (sub) begin
        s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
        hs = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
        v = (a[7] & ~b[7] & ~s[7]) | (~a[7] & b[7] & s[7]);
      end else begin
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        hs = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        v = (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]);
      end
      alu8 = {hs[4], v, s[8], s[7:0]};
    end
  endfunction

  // ************************************************************
  // instruction fields
  // ************************************************************
  wire [15:0] ir = pm_rdata;
  wire [3:0] op = ir[15:12];
  wire [3:0] sub4 = ir[11:8];
  wire [1:0] sub2 = ir[11:10];
  wire [4:0] fd = ir[9:5];
  wire [4:0] fr = ir[4:0];
  wire [4:0] kd = {1'b1, ir[11:8]};
  wire [7:0] kk = ir[7:0];
  wire [4:0] wd = {2'b11, ir[11:10], 1'b0};
  wire [4:0] wd_hi = {2'b11, ir[11:10], 1'b1};
  wire [4:0] pidx = {2'b11, ir[9:8], 1'b0};
  wire [4:0] pidx_hi = {2'b11, ir[9:8], 1'b1};
  wire [4:0] td = ir[7:3];
  wire [2:0] tb = ir[2:0];
  wire cflag = status_register[`TMIE_SR_C];
  wire tflag = status_register[`TMIE_SR_T];
  wire [15:0] pc1 = pc + 16'h0001;

  // operands and results
  wire [7:0] src_d = rf[fd];
  wire [7:0] src_r = rf[fr];
  wire [7:0] src_k = rf[kd];
  wire [7:0] src_t = rf[td];
  wire [15:0] zptr = {rf[31], rf[30]};
  wire [15:0] yptr = {rf[29], rf[28]};
  wire [15:0] ptr_sel = {rf[pidx_hi], rf[pidx]};
  wire [15:0] wval = {rf[wd_hi], rf[wd]};
  wire [10:0] add_res = alu8(src_d, src_r, cflag, 1'b0);
  wire [10:0] subk_res = alu8(src_k, kk, cflag, 1'b1);
  wire [7:0] and_res = src_k & kk;
  wire [7:0] clr_res = src_k & (`TMIE_MASK_ALL - kk);
  wire [16:0] wsum = {1'b0, wval} + {11'h000, ir[5:0]};
  wire [16:0] wdiff = {1'b0, wval} - {11'h000, ir[5:0]};
  wire wsum_v = ~wval[15] & wsum[15];
  wire wdiff_v = wval[15] & ~wdiff[15];
  wire [7:0] bit_one = 8'h01 << tb;
  wire [7:0] tload_res = (src_t & ~bit_one) | ({8{tflag}} & bit_one);
  wire [7:0] rot_res = {cflag, src_r[7:1]};
  wire io_bit = io_low_view[ir[7:0]];
  wire [15:0] br_target = pc1 + {{9{ir[9]}}, ir[9:3]};
  wire nxv = status_register[`TMIE_SR_N] ^ status_register[`TMIE_SR_V];
  wire is_two_word = (op == `TMIE_OP_MISC) && (sub4 == `TMIE_MISC_STORE_DIRECT);
  reg br_take;

  assign pm_addr = pc;

  // branch condition
  always @* begin
    case (sub2)
      `TMIE_BR_FLAG_SET: br_take = status_register[ir[2:0]]; // see RL10
      `TMIE_BR_FLAG_CLEAR: br_take = ~status_register[ir[2:0]];
      `TMIE_BR_GE_SIGNED: br_take = ~nxv; // see RL11
      default: br_take = nxv; // see RL11
    endcase
  end

  // ************************************************************
  // apb slave
  // ************************************************************
  wire apb_setup = psel & ~penable;
  wire apb_take = psel & penable & pready & pwrite;
  wire apb_hit = (paddr == `TMIE_ADDR_CTRL) || (paddr == `TMIE_ADDR_PC) ||
    (paddr == `TMIE_ADDR_STATUS) || (paddr == `TMIE_ADDR_SP);
  wire sp_wr = apb_take && (paddr == `TMIE_ADDR_SP);
  reg [31:0] rd_mux;

  // read data selection
  always @* begin
    case (paddr)
      `TMIE_ADDR_CTRL: rd_mux = {30'h0, (wait_cnt != 2'h0), run_en};
      `TMIE_ADDR_PC: rd_mux = {16'h0000, pc};
      `TMIE_ADDR_STATUS: rd_mux = {24'h000000, status_register};
      `TMIE_ADDR_SP: rd_mux = {16'h0000, sp};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // zero-wait answer: pready rises in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      run_en <= `TMIE_RUN_RESET;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~apb_hit;
      prdata <= (apb_setup & ~pwrite) ? rd_mux : 32'h00000000;
      if (apb_take && (paddr == `TMIE_ADDR_CTRL)) begin
        run_en <= pwdata[`TMIE_CTRL_RUN];
      end
    end
  end

  // ************************************************************
  // fetch, decode and execute
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 32; i = i + 1) begin
        rf[i] <= 8'h00;
      end
      pc <= 16'h0000;
      sp <= `TMIE_SP_RESET;
      status_register <= 8'h00;
      wait_cnt <= 2'h0;
      phase <= PH_IDLE;
      hold_d <= 5'h00;
      hold_b <= 1'b0;
      ret_pc <= 16'h0000;
      skip_next <= 1'b0;
      skip_raw <= 1'b0;
      dm_addr <= 16'h0000;
      dm_wdata <= 8'h00;
      dm_we <= 1'b0;
      dm_re <= 1'b0;
      io_bit_addr <= 5'h00;
      io_bit_num <= 3'h0;
      io_bit_val <= 1'b0;
      io_bit_we <= 1'b0;
    end else begin
      dm_we <= 1'b0;
      dm_re <= 1'b0;
      io_bit_we <= 1'b0;
      if (sp_wr) begin
        sp <= pwdata[15:0];
      end
      if (wait_cnt != 2'h0) begin
        // extra cycles: no fetch, no issue
        wait_cnt <= wait_cnt - 2'h1; // see RL24
        phase <= PH_IDLE;
        case (phase)
          PH_LOAD: rf[hold_d] <= dm_rdata; // see RL16 RL18
          PH_PMREAD: begin
            rf[hold_d] <= hold_b ? pm_rdata[15:8] : pm_rdata[7:0]; // see RL19
            rf[30] <= zptr[7:0] + 8'h01;
            rf[31] <= zptr[15:8] + {7'h00, (zptr[7:0] == 8'hff)};
            pc <= ret_pc;
          end
          PH_CALL_HI: begin
            dm_addr <= sp; // see RL7
            dm_wdata <= ret_pc[15:8];
            dm_we <= 1'b1;
            sp <= sp - 16'h0001;
          end
          PH_STORE_DIRECT: begin
            dm_addr <= pm_rdata;
            dm_wdata <= rf[hold_d];
            dm_we <= 1'b1;
            pc <= pc1;
          end
          default: ;
        endcase
      end else if (run_en) begin
        pc <= pc1;
        if (skip_raw) begin
          skip_raw <= 1'b0; // second word of a skipped pair, see RL8
        end else if (skip_next) begin
          skip_next <= 1'b0; // see RL8 RL9
          skip_raw <= is_two_word;
        end else begin
          case (op)
            `TMIE_OP_MISC: begin
              case (sub4)
                `TMIE_MISC_CALL_Z: begin
                  dm_addr <= sp; // see RL7
                  dm_wdata <= pc1[7:0];
                  dm_we <= 1'b1;
                  sp <= sp - 16'h0001;
                  ret_pc <= pc1;
                  pc <= zptr;
                  phase <= PH_CALL_HI;
                  wait_cnt <= `TMIE_WAIT_3CLK;
                end
                `TMIE_MISC_FLAG_SET: status_register[ir[2:0]] <= 1'b1; // see RL21
                `TMIE_MISC_FLAG_CLR: status_register[ir[2:0]] <= 1'b0; // see RL21
                `TMIE_MISC_ROTATE: begin
                  rf[fr] <= rot_res; // see RL13
                  status_register <= fmerge(status_register,
                    fbyte(1'b0, 1'b0, cflag ^ src_r[0], src_r[0], rot_res), `TMIE_FM_SHIFT);
                end
                `TMIE_MISC_PUSH: begin
                  dm_addr <= sp; // see RL20
                  dm_wdata <= src_r;
                  dm_we <= 1'b1;
                  sp <= sp - 16'h0001;
                  wait_cnt <= `TMIE_WAIT_2CLK;
                end
                `TMIE_MISC_STORE_DIRECT: begin
                  hold_d <= fr;
                  phase <= PH_STORE_DIRECT;
                  wait_cnt <= `TMIE_WAIT_2CLK;
                end
                default: ;
              endcase
            end
            `TMIE_OP_ADD_CARRY: begin
              rf[fd] <= add_res[7:0]; // see RL1
              status_register <= fmerge(status_register,
                fbyte(add_res[10], 1'b0, add_res[9], add_res[8], add_res[7:0]), `TMIE_FM_ARITH);
            end
            `TMIE_OP_CMP_SKIP: skip_next <= (src_d == src_r); // see RL8
            `TMIE_OP_SUBC_K: begin
              rf[kd] <= subk_res[7:0]; // see RL4
              status_register <= fmerge(status_register,
                fbyte(subk_res[10], 1'b0, subk_res[9], subk_res[8], subk_res[7:0]),
                `TMIE_FM_ARITH);
            end
            `TMIE_OP_AND_K: begin
              rf[kd] <= and_res; // see RL6
              status_register <= fmerge(status_register,
                fbyte(1'b0, 1'b0, 1'b0, 1'b0, and_res), `TMIE_FM_LOGIC);
            end
            `TMIE_OP_CLR_MASK: begin
              rf[kd] <= clr_res; // see RL5
              status_register <= fmerge(status_register,
                fbyte(1'b0, 1'b0, 1'b0, 1'b0, clr_res), `TMIE_FM_LOGIC);
            end
            `TMIE_OP_ADD_WORD: begin
              rf[wd] <= wsum[7:0]; // see RL2
              rf[wd_hi] <= wsum[15:8];
              status_register <= fmerge(status_register, {3'b000, wsum[15] ^ wsum_v,
                wsum_v, wsum[15], (wsum[15:0] == 16'h0000), wsum[16]}, `TMIE_FM_WORD);
              wait_cnt <= `TMIE_WAIT_2CLK;
            end
            `TMIE_OP_SUB_WORD: begin
              rf[wd] <= wdiff[7:0]; // see RL3
              rf[wd_hi] <= wdiff[15:8];
              status_register <= fmerge(status_register, {3'b000, wdiff[15] ^ wdiff_v,
                wdiff_v, wdiff[15], (wdiff[15:0] == 16'h0000), wdiff[16]}, `TMIE_FM_WORD);
              wait_cnt <= `TMIE_WAIT_2CLK;
            end
            `TMIE_OP_IO_BIT: begin
              // the 5-bit address field reaches io 0x00 to 0x1f only, see RL22
              case (sub2)
                `TMIE_IO_SET, `TMIE_IO_CLEAR: begin
                  io_bit_addr <= ir[7:3]; // single-bit write, see RL12 RL23
                  io_bit_num <= ir[2:0];
                  io_bit_val <= (sub2 == `TMIE_IO_SET);
                  io_bit_we <= 1'b1;
                  wait_cnt <= `TMIE_WAIT_2CLK;
                end
                `TMIE_IO_SKIP_SET: skip_next <= io_bit; // see RL9
                default: skip_next <= ~io_bit;
              endcase
            end
            `TMIE_OP_BRANCH: begin
              if (br_take) begin
                pc <= br_target; // see RL10 RL11
                wait_cnt <= `TMIE_WAIT_2CLK;
              end
            end
            `TMIE_OP_TFLAG: begin
              if (ir[11]) begin
                rf[td] <= tload_res; // see RL15
              end else begin
                status_register[`TMIE_SR_T] <= src_t[tb]; // see RL14
              end
            end
            `TMIE_OP_MEM: begin
              case (sub2)
                `TMIE_MEM_LOAD_PREDEC: begin
                  rf[pidx] <= ptr_sel[7:0] - 8'h01; // see RL16
                  rf[pidx_hi] <= ptr_sel[15:8] - {7'h00, (ptr_sel[7:0] == 8'h00)};
                  dm_addr <= ptr_sel - 16'h0001;
                  dm_re <= 1'b1;
                  hold_d <= fr;
                  phase <= PH_LOAD;
                  wait_cnt <= `TMIE_WAIT_2CLK;
                end
                `TMIE_MEM_WRITE_POSTINC: begin
                  dm_addr <= ptr_sel; // see RL17
                  dm_wdata <= src_r;
                  dm_we <= 1'b1;
                  rf[pidx] <= ptr_sel[7:0] + 8'h01;
                  rf[pidx_hi] <= ptr_sel[15:8] + {7'h00, (ptr_sel[7:0] == 8'hff)};
                  wait_cnt <= `TMIE_WAIT_2CLK;
                end
                `TMIE_MEM_PM_POSTINC: begin
                  ret_pc <= pc1; // see RL19
                  pc <= {1'b0, zptr[15:1]};
                  hold_b <= zptr[0];
                  hold_d <= fr;
                  phase <= PH_PMREAD;
                  wait_cnt <= `TMIE_WAIT_3CLK;
                end
                default: ;
              endcase
            end
            `TMIE_OP_LOAD_DISP: begin
              dm_addr <= (ir[11] ? yptr : zptr) + {10'h000, ir[10:5]}; // see RL18
              dm_re <= 1'b1;
              hold_d <= fr;
              phase <= PH_LOAD;
              wait_cnt <= `TMIE_WAIT_2CLK;
            end
            default: ;
          endcase
        end
      end
    end
  end

endmodule // tmie_core

// ===== sim/tmie_core_properties.sv
// checker for the execute core: apb answer timing and stall pulses.
// assumes it is bound to tmie_core and sees only that module's ports.
`timescale 1ns/1ps
module tmie_core_props (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // memories and io
  input wire [15:0] pm_addr,
  input wire [15:0] dm_addr,
  input wire dm_we,
  input wire dm_re,
  input wire io_bit_we
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ********************
  // sequences
  // ********************
  sequence s_setup;
    psel && !penable;
  endsequence
  // second call byte goes out while the fetch address waits, so the late
  // byte of a direct write followed at once by a push or call never matches
  sequence s_call;
    dm_we ##1 (dm_we && $stable(pm_addr));
  endsequence
  // apb answers in the cycle after setup, for one cycle only
  apb_zero_wait_a: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  unmapped_error_a: assert property (pready && paddr[11:4] != 8'h00 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (pready && paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  // io bit writes take two clocks and hold the fetch meanwhile
  io_two_clock_a: assert property (io_bit_we |=> !io_bit_we && $stable(pm_addr))
    else $error("io bit op not two clocks");
  // loads take two clocks and hold the fetch meanwhile
  load_two_clock_a: assert property (dm_re |=> !dm_re && $stable(pm_addr))
    else $error("load not two clocks");
  // call pushes two bytes downward while the fetch waits
  call_stack_a: assert property (s_call |-> dm_addr == $past(dm_addr) - 16'h0001)
    else $error("call push order wrong");
  call_hold_a: assert property (s_call |=> $stable(pm_addr))
    else $error("fetch moved during call");
endmodule // tmie_core_props
bind tmie_core tmie_core_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pm_addr(pm_addr), .dm_addr(dm_addr), .dm_we(dm_we), .dm_re(dm_re), .io_bit_we(io_bit_we));

// ===== sim/tmie_mem_model.sv
// behavioural program memory, data memory and low io space.
// assumes the core samples read data combinationally in the same cycle.
`timescale 1ns/1ps
module tmie_mem_model (
  // clock
  input wire pclk,
  // program memory
  input wire [15:0] pm_addr,
  output wire [15:0] pm_rdata,
  // data memory
  input wire [15:0] dm_addr,
  input wire [7:0] dm_wdata,
  input wire dm_we,
  input wire dm_re,
  output wire [7:0] dm_rdata,
  // io bit port
  input wire [4:0] io_bit_addr,
  input wire [2:0] io_bit_num,
  input wire io_bit_val,
  input wire io_bit_we,
  output logic [255:0] io_low_view
);
  logic [15:0] pm [0:255];
  logic [7:0] dm [0:255];
  logic [7:0] io_reg [0:31];
  // program words answer at once
  assign pm_rdata = pm[pm_addr[7:0]];
  // data only while a read is marked, inverted junk otherwise
  assign dm_rdata = dm_re ? dm[dm_addr[7:0]] : ~dm[dm_addr[7:0]];
  // byte writes and single-bit io updates
  always @(posedge pclk) begin
    if (dm_we) begin
      dm[dm_addr[7:0]] <= dm_wdata;
    end
    if (io_bit_we) begin
      io_reg[io_bit_addr][io_bit_num] <= io_bit_val;
    end
  end
  // flat view of the bit-addressable range
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      io_low_view[i*8 +: 8] = io_reg[i];
    end
  end
endmodule // tmie_mem_model

// ===== sim/tiny_mcu_instruction_execute_tb_top.sv
// testbench for the execute core: small programs, memory and status checks.
// assumes the memory model beside the core and the bound checker.
`timescale 1ns/1ps
`include "tmie_consts.vh"
module tiny_mcu_instruction_execute_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, pcv;
  logic [15:0] pm_addr, pm_rdata, dm_addr;
  logic [7:0] dm_wdata, dm_rdata;
  logic dm_we, dm_re, io_bit_val, io_bit_we;
  logic [4:0] io_bit_addr;
  logic [2:0] io_bit_num;
  logic [255:0] io_low_view;
  logic [71:0] r;
  int n_errors = 0;
  int checks = 0;
  // pre-op, op, reg, a, b, stored byte, status
  logic [71:0] rows [0:19] = '{
    72'h0200_1211_10_0f_01_11_20, 72'h0000_1211_10_80_80_00_0b,
    72'h0200_3001_10_00_00_fe_25, 72'h0200_40f0_10_8f_00_80_05,
    72'h0200_500f_10_0f_00_00_03, 72'h0200_0410_10_01_00_80_05,
    72'h0206_a883_10_00_00_08_40, 72'h0000_0203_10_5a_00_5a_08,
    72'h0203_0303_10_5a_00_5a_00, 72'h0000_a087_10_80_00_80_40,
    72'h0000_6001_18_ff_ff_00_03, 72'h0000_7001_18_00_00_ff_15,
    72'h0000_2211_10_33_33_ee_00, 72'h0000_2211_10_33_34_33_00,
    72'h0000_9810_10_44_00_ee_00, 72'h0202_9c10_10_44_00_ee_04,
    72'h0000_9c10_10_44_00_44_00, 72'h0200_9010_10_44_00_ee_01,
    72'h802a_882a_10_44_00_ee_00, 72'h842a_882a_10_44_00_44_00};
  // pointer, stack, io and call program
  logic [15:0] prog [0:12] = '{16'hc010, 16'hc05e, 16'h8029, 16'h842f, 16'h0510, 16'hb710,
    16'hb311, 16'hbb12, 16'h0611, 16'h0041, 16'h0612, 16'h0042, 16'h0100};
  tmie_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re), .dm_rdata(dm_rdata),
    .io_bit_addr(io_bit_addr), .io_bit_num(io_bit_num), .io_bit_val(io_bit_val),
    .io_bit_we(io_bit_we), .io_low_view(io_low_view));
  tmie_mem_model mdl (.pclk(pclk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re),
    .dm_rdata(dm_rdata), .io_bit_addr(io_bit_addr), .io_bit_num(io_bit_num),
    .io_bit_val(io_bit_val), .io_bit_we(io_bit_we), .io_low_view(io_low_view));
  // clock at 25 ns
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one apb transfer; only the watchdog ends a wait for ready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // enter reset and clear every memory
  task hold();
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    for (int i = 0; i < 256; i++) begin
      mdl.pm[i] = 16'h0000;
      mdl.dm[i] = 8'h00;
    end
    for (int i = 0; i < 32; i++) begin
      mdl.io_reg[i] = 8'h00;
    end
  endtask
  // leave reset, 8 cycles after the start, then run
  task go(input int n);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (n) @(posedge pclk);
  endtask
  task close_out();
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (8000) @(posedge pclk);
    n_errors++;
    close_out();
  end
  // ********************
  // main sequence
  // ********************
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0;
    for (int i = 0; i < 20; i++) begin
      hold();
      r = rows[i];
      mdl.dm[0] = r[31:24];
      mdl.dm[1] = r[23:16];
      mdl.dm[8'h40] = 8'hee;
      mdl.pm[0] = {8'hc0, r[39:32]};
      mdl.pm[1] = {8'hc0, r[39:32] + 8'h21};
      mdl.pm[2] = r[71:56];
      mdl.pm[3] = r[55:40];
      mdl.pm[4] = {8'h06, r[39:32]};
      mdl.pm[5] = 16'h0040;
      go(30);
      chk("stored byte", {24'h0, mdl.dm[8'h40]}, {24'h0, r[15:8]});
      apb(1'b0, `TMIE_ADDR_STATUS, 32'h0);
      chk("status", q, {24'h0, r[7:0]});
    end
    apb(1'b0, `TMIE_ADDR_SP, 32'h0);
    chk("sp reset", q, 32'h0000_00ff);
    // pointer, stack, io and call sequence
    hold();
    mdl.dm[0] = 8'h3c;
    mdl.dm[2] = 8'h20;
    mdl.io_reg[5] = 8'ha5;
    mdl.pm[16'h10] = 16'h0077;
    for (int i = 0; i < 13; i++) begin
      mdl.pm[i] = prog[i];
    end
    go(40);
    chk("io reg", {24'h0, mdl.io_reg[5]}, 32'h27);
    chk("push", {24'h0, mdl.dm[8'hff]}, 32'h3c);
    chk("post inc write", {24'h0, mdl.dm[8'h20]}, 32'h3c);
    chk("pre dec load", {24'h0, mdl.dm[8'h41]}, 32'h3c);
    chk("pm read", {24'h0, mdl.dm[8'h42]}, 32'h77);
    chk("ret low", {24'h0, mdl.dm[8'hfe]}, 32'h0d);
    chk("ret high", {24'h0, mdl.dm[8'hfd]}, 32'h00);
    apb(1'b0, `TMIE_ADDR_SP, 32'h0);
    chk("sp after", q, 32'h0000_00fc);
    apb(1'b0, `TMIE_ADDR_CTRL, 32'h0);
    chk("ctrl", q, 32'h1);
    apb(1'b1, `TMIE_ADDR_SP, 32'h80);
    apb(1'b0, `TMIE_ADDR_SP, 32'h0);
    chk("sp write", q, 32'h80);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {e, q[30:0]}, 32'h8000_0000);
    apb(1'b1, `TMIE_ADDR_CTRL, 32'h0);
    apb(1'b0, `TMIE_ADDR_PC, 32'h0);
    pcv = q;
    apb(1'b0, `TMIE_ADDR_PC, 32'h0);
    chk("stopped pc", q, pcv);
    close_out();
  end
endmodule // tiny_mcu_instruction_execute_tb_top
